// ===== hw/supply_mode_supervisor.sv
// Operating-mode supervisor: chip modes, supply enables, CAN transceiver mode.
// Assumes decoded SPI frames from same-clock logic, pins and analog flags
// from outside the clock domain, and a 10 MHz clock.
// Operation
// - Failure 3 or 8: open high switch, CANH off
// - Failure 4, 6, 7: open low switches, CANL off
// - Failures 1, 2, 5 change nothing
// - Full duplex: transmit, receive, full detection
// - Listen only: no transmit, receive low on TX/dominant
// - Low power: drivers off, low term to battery
// - Reset mode at least 1ms, then await config
// - Logic supply failing 100ms: version-dependent exit
// - Await config: only logic regulator on
// - No SPI within 75ms: go to sleep
// - Watchdog timing word starts watchdog, enters normal
// - Await config ignores commands except watchdog timing and emergency
// - Normal: both regulators, transceiver regulator off on overload, switched output as commanded
// - Normal: watchdog timeout or undervoltage resets host
// - Standby: logic on, transceiver off, watchdog runs
// - Standby exits on timeout, undervoltage, external reset
// - Sleep: regulators off; wake-ups go to reset mode
// - Sleep entered by command, config timeout, or (version A) logic supply failing 100ms in reset mode
// - Emergency: all supplies off; exit on battery loss
// - Transceiver low power outside normal mode
// - Transceiver regulator off forces low power, sticky
`timescale 1ns/100ps
`include "supply_mode_cfg.svh"
module supply_mode_supervisor #(
	parameter int  RESET_HOLD_CYC  = `RESET_HOLD_CYC,
	parameter int  V1_FAIL_CYC     = `V1_FAIL_CYC,
	parameter int  CONFIG_WAIT_CYC = `CONFIG_WAIT_CYC,
	parameter bit  VERSION_A       = 1'b1,
	parameter int  FAIL_W          = `FAIL_W
) (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       frame_end,
	input  wire supply_mode_pkg::spi_frame_t frame,
	input  wire logic                       wd_fault,
	input  wire logic                       logic_supply_low,
	input  wire logic                       xcvr_supply_overload,
	input  wire logic                       battery_loss_detection,
	input  wire logic                       host_reset_in,
	input  wire logic                       wake_can,
	input  wire logic                       wake_cyclic,
	input  wire logic                       wake_permanent,
	input  wire logic                       wake_forced,
	input  wire logic                       wake_spi,
	input  wire logic                       tx_in,
	input  wire logic                       bus_dominant,
	input  wire logic [FAIL_W-1:0]          failure,
	output logic                            rx_out,
	output logic                            host_reset_line_o,
	output logic                            host_reset_line_oe,
	output logic                            watchdog_run,
	output supply_mode_pkg::chip_mode_t     mode,
	output logic [1:0]                      xcvr_mode,
	output supply_mode_pkg::supply_en_t     supply_en,
	output supply_mode_pkg::xcvr_ctl_t      xcvr_ctl,
	output logic                            bus_wake_detect_en
);
	localparam int SYNC_W = 11;

	typedef struct packed {
		logic [SYNC_W-1:0]           in_s1;
		logic [SYNC_W-1:0]           in_s2;
		supply_mode_pkg::chip_mode_t mode;
		logic [23:0]                 hold_cnt;
		logic [23:0]                 fail_cnt;
		logic                        wd_active;
		logic                        v3_cmd;
		logic [1:0]                  xcvr;
		logic                        host_rst;
		logic                        rx;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic   rst_n;
	logic   open_high_term;
	logic   open_low_term;
	logic   canh_off;
	logic   canl_off;

	// Reset release stages, kept apart because they run on the raw reset
	logic [1:0] rst_sync_q;

	// Synchronised copies of the pin and analog inputs
	logic       wdf;
	logic       v1_low;
	logic       v2_ovl;
	logic       bat_loss;
	logic       ext_rst;
	logic       wk_any;
	logic       tx_s;
	logic       dom_s;
	logic       bus_dominant_s1;
	logic       bus_dominant_s;

	function automatic logic timer_done(input logic [23:0] cnt, input int limit);
		timer_done = (cnt >= 24'(limit - 1));
	endfunction

	// Reset release synchroniser
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign wdf      = s_q.in_s2[0];
	assign v1_low   = s_q.in_s2[1];
	assign v2_ovl   = s_q.in_s2[2];
	assign bat_loss = s_q.in_s2[3];
	assign ext_rst  = s_q.in_s2[4];
	assign wk_any   = |s_q.in_s2[9:5];
	assign tx_s     = s_q.in_s2[10];
	assign dom_s    = bus_dominant_s;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_dominant_s1 <= 1'b0;
			bus_dominant_s  <= 1'b0;
		end else begin
			bus_dominant_s1 <= bus_dominant;
			bus_dominant_s  <= bus_dominant_s1;
		end
	end

	logic [FAIL_W-1:0] fail_s1, fail_s;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fail_s1 <= '0;
			fail_s  <= '0;
		end else begin
			fail_s1 <= failure;
			fail_s  <= fail_s1;
		end
	end

	always_comb begin
		s_d        = s_q;
		s_d.in_s1  = {tx_in, wake_spi, wake_forced, wake_permanent, wake_cyclic, wake_can,
		              host_reset_in, battery_loss_detection, xcvr_supply_overload,
		              logic_supply_low, wd_fault};
		s_d.in_s2  = s_q.in_s1;
		s_d.host_rst = 1'b0;
		s_d.hold_cnt = s_q.hold_cnt + 24'h000001;
		unique case (s_q.mode)
			supply_mode_pkg::ST_RESET: begin
				s_d.host_rst = 1'b1;
				s_d.wd_active = 1'b0;
				s_d.fail_cnt = v1_low ? s_q.fail_cnt + 24'h000001 : 24'h000000;
				if (v1_low && timer_done(s_q.fail_cnt, V1_FAIL_CYC)) begin
					if (VERSION_A) begin
						s_d.mode = supply_mode_pkg::ST_SLEEP;
						s_d.hold_cnt = 24'h000000;
					end
				end else if (!v1_low && timer_done(s_q.hold_cnt, RESET_HOLD_CYC)) begin
					s_d.mode = supply_mode_pkg::ST_AWAIT;
					s_d.hold_cnt = 24'h000000;
					s_d.v3_cmd = 1'b0;
					s_d.xcvr = `XCVR_LOW_POWER;
				end
			end
			supply_mode_pkg::ST_AWAIT: begin
				if (frame_end && frame.cmd == `CMD_EMERGENCY) begin
					s_d.mode = supply_mode_pkg::ST_EMERG;
				end else if (frame_end && frame.cmd == `CMD_WD_TIMING) begin
					s_d.mode = supply_mode_pkg::ST_NORMAL;
					s_d.wd_active = 1'b1;
				end else if (v1_low) begin
					s_d.mode = supply_mode_pkg::ST_RESET;
					s_d.hold_cnt = 24'h000000;
				end else if (timer_done(s_q.hold_cnt, CONFIG_WAIT_CYC)) begin
					s_d.mode = supply_mode_pkg::ST_SLEEP;
				end
			end
			supply_mode_pkg::ST_NORMAL, supply_mode_pkg::ST_STANDBY: begin
				if (wdf || v1_low || (s_q.mode == supply_mode_pkg::ST_STANDBY && ext_rst)) begin
					s_d.mode = supply_mode_pkg::ST_RESET;
					s_d.hold_cnt = 24'h000000;
					s_d.fail_cnt = 24'h000000;
				end else if (frame_end) begin
					unique case (frame.cmd)
						`CMD_NORMAL:    s_d.mode = supply_mode_pkg::ST_NORMAL;
						`CMD_STANDBY:   s_d.mode = supply_mode_pkg::ST_STANDBY;
						`CMD_SLEEP:     s_d.mode = supply_mode_pkg::ST_SLEEP;
						`CMD_EMERGENCY: s_d.mode = supply_mode_pkg::ST_EMERG;
						default:        s_d.mode = s_q.mode;
					endcase
					if (frame.cmd == `CMD_NORMAL || frame.cmd == `CMD_STANDBY) begin
						s_d.v3_cmd = frame.v3_on;
					end
					if (frame.cmd == `CMD_XCVR && s_q.mode == supply_mode_pkg::ST_NORMAL) begin
						s_d.xcvr = frame.xcvr;
					end
				end
				if (s_d.mode != supply_mode_pkg::ST_NORMAL || v2_ovl) begin
					s_d.xcvr = `XCVR_LOW_POWER;
				end
				s_d.hold_cnt = 24'h000000;
			end
			supply_mode_pkg::ST_SLEEP: begin
				s_d.wd_active = 1'b0;
				s_d.xcvr = `XCVR_LOW_POWER;
				if (wk_any) begin
					s_d.mode = supply_mode_pkg::ST_RESET;
					s_d.hold_cnt = 24'h000000;
					s_d.fail_cnt = 24'h000000;
				end
			end
			supply_mode_pkg::ST_EMERG: begin
				s_d.wd_active = 1'b0;
				s_d.xcvr = `XCVR_LOW_POWER;
				if (bat_loss) begin
					s_d.mode = supply_mode_pkg::ST_RESET;
					s_d.hold_cnt = 24'h000000;
					s_d.fail_cnt = 24'h000000;
				end
			end
			default: begin
				s_d.mode = supply_mode_pkg::ST_RESET;
			end
		endcase
		// Listen only: receive line low on local transmit or dominant bus
		s_d.rx = !(s_q.xcvr == `XCVR_LISTEN_ONLY ? (!tx_s || dom_s) : dom_s);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.in_s1    <= '0;
			s_q.in_s2    <= '0;
			s_q.mode     <= supply_mode_pkg::ST_RESET;
			s_q.hold_cnt <= 24'h000000;
			s_q.fail_cnt <= 24'h000000;
			s_q.wd_active <= 1'b0;
			s_q.v3_cmd   <= 1'b0;
			s_q.xcvr     <= `XCVR_LOW_POWER;
			s_q.host_rst <= 1'b1;
			s_q.rx       <= 1'b1;
		end else begin
			s_q.in_s1    <= s_d.in_s1;
			s_q.in_s2    <= s_d.in_s2;
			s_q.mode     <= s_d.mode;
			s_q.hold_cnt <= s_d.hold_cnt;
			s_q.fail_cnt <= s_d.fail_cnt;
			s_q.wd_active <= s_d.wd_active;
			s_q.v3_cmd   <= s_d.v3_cmd;
			s_q.xcvr     <= s_d.xcvr;
			s_q.host_rst <= s_d.host_rst;
			s_q.rx       <= s_d.rx;
		end
	end

	bus_failure_map #(
		.FAIL_W(FAIL_W)
	) u_fail (
		.clk           (clk),
		.rst_n         (rst_n),
		.failure       (fail_s),
		.open_high_term(open_high_term),
		.open_low_term (open_low_term),
		.canh_off      (canh_off),
		.canl_off      (canl_off)
	);

	logic active_bus;
	assign active_bus = (s_q.xcvr != `XCVR_LOW_POWER);

	always_comb begin
		// Supplies per chip mode
		supply_en.logic_supply_regulator = s_q.mode inside {supply_mode_pkg::ST_RESET,
			supply_mode_pkg::ST_AWAIT, supply_mode_pkg::ST_NORMAL,
			supply_mode_pkg::ST_STANDBY};
		supply_en.transceiver_supply_regulator =
			(s_q.mode == supply_mode_pkg::ST_NORMAL) && !v2_ovl;
		supply_en.switched_battery_output = s_q.v3_cmd &&
			(s_q.mode inside {supply_mode_pkg::ST_NORMAL, supply_mode_pkg::ST_STANDBY});
		// Transceiver actions per bus mode
		xcvr_ctl.tx_en = (s_q.xcvr == `XCVR_FULL_DUPLEX);
		xcvr_ctl.rx_en = active_bus;
		xcvr_ctl.full_detect_en = active_bus;
		xcvr_ctl.canh_drv_en = xcvr_ctl.tx_en && !canh_off;
		xcvr_ctl.canl_drv_en = xcvr_ctl.tx_en && !canl_off;
		xcvr_ctl.high_term_ground_switch = !open_high_term;
		xcvr_ctl.low_term_supply_switch = active_bus && !open_low_term;
		xcvr_ctl.low_term_battery_switch = !active_bus && !open_low_term;
	end

	// Partial detection of failures 3, 4, 7, 8 stays in the external detector
	assign bus_wake_detect_en = !active_bus;
	assign mode               = s_q.mode;
	assign xcvr_mode          = s_q.xcvr;
	assign watchdog_run       = s_q.wd_active;
	assign rx_out             = s_q.rx;
	assign host_reset_line_o  = 1'b0;
	assign host_reset_line_oe = s_q.host_rst;
endmodule

// ===== hw/supply_mode_cfg.svh
// Constants for the supply and CAN mode supervisor: codes and timing counts.
// Assumes a 10 MHz core clock; times are given in microseconds.
`ifndef SUPPLY_MODE_CFG_SVH
`define SUPPLY_MODE_CFG_SVH
`define CLK_MHZ            10
`define RESET_HOLD_US      1000
`define RESET_HOLD_CYC     (`RESET_HOLD_US * `CLK_MHZ)
`define V1_FAIL_US         100000
`define V1_FAIL_CYC        (`V1_FAIL_US * `CLK_MHZ)
`define CONFIG_WAIT_US     75000
`define CONFIG_WAIT_CYC    (`CONFIG_WAIT_US * `CLK_MHZ)
`define CMD_NONE           3'h0
`define CMD_WD_TIMING      3'h1
`define CMD_NORMAL         3'h2
`define CMD_STANDBY        3'h3
`define CMD_SLEEP          3'h4
`define CMD_EMERGENCY      3'h5
`define CMD_XCVR           3'h6
`define XCVR_LOW_POWER     2'h0
`define XCVR_FULL_DUPLEX   2'h1
`define XCVR_LISTEN_ONLY   2'h2
`define FAIL_W             8
`endif

// ===== hw/supply_mode_pkg.sv
// Types shared by the supply and CAN mode supervisor.
// Assumes supply_mode_cfg.svh is on the include path.
`include "supply_mode_cfg.svh"
package supply_mode_pkg;
	typedef enum logic [5:0] {
		ST_RESET   = 6'h01,
		ST_AWAIT   = 6'h02,
		ST_NORMAL  = 6'h04,
		ST_STANDBY = 6'h08,
		ST_SLEEP   = 6'h10,
		ST_EMERG   = 6'h20
	} chip_mode_t;

	typedef struct packed {
		logic [2:0] cmd;
		logic       v3_on;
		logic [1:0] xcvr;
	} spi_frame_t;

	typedef struct packed {
		logic high_term_ground_switch;
		logic low_term_supply_switch;
		logic low_term_battery_switch;
		logic canh_drv_en;
		logic canl_drv_en;
		logic rx_en;
		logic tx_en;
		logic full_detect_en;
	} xcvr_ctl_t;

	typedef struct packed {
		logic logic_supply_regulator;
		logic transceiver_supply_regulator;
		logic switched_battery_output;
	} supply_en_t;
endpackage

// ===== hw/bus_failure_map.sv
// Maps detected bus failures to termination switch and driver actions.
// Assumes failure flags arrive synchronised; bit n-1 is failure type n.
`timescale 1ns/100ps
`include "supply_mode_cfg.svh"
module bus_failure_map #(
	parameter int FAIL_W = `FAIL_W
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [FAIL_W-1:0] failure,
	output logic                   open_high_term,
	output logic                   open_low_term,
	output logic                   canh_off,
	output logic                   canl_off
);
	logic [3:0] act_d;
	logic [3:0] act_q;

	always_comb begin
		act_d[0] = failure[2] | failure[7];
		act_d[2] = act_d[0];
		act_d[1] = failure[3] | failure[5] | failure[6];
		act_d[3] = act_d[1];
		// Failures 1, 2 and 5 take no part in any action
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_q <= 4'h0;
		end else begin
			act_q <= act_d;
		end
	end

	assign open_high_term = act_q[0];
	assign open_low_term  = act_q[1];
	assign canh_off       = act_q[2];
	assign canl_off       = act_q[3];
endmodule

// ===== test/supply_mode_props.sv
// Checker for the supply mode supervisor, bound to its top ports.
// Assumes one clock domain and the asynchronous active-low resetn.
`timescale 1ns/100ps
`include "supply_mode_cfg.svh"
module supply_mode_props #(
	parameter int RESET_HOLD_CYC = 20
) (
	input wire logic                        clk,
	input wire logic                        resetn,
	input wire logic                        frame_end,
	input wire supply_mode_pkg::spi_frame_t frame,
	input wire logic                        watchdog_run,
	input wire logic                        host_reset_line_oe,
	input wire supply_mode_pkg::chip_mode_t mode,
	input wire logic [1:0]                  xcvr_mode,
	input wire supply_mode_pkg::supply_en_t supply_en,
	input wire supply_mode_pkg::xcvr_ctl_t  xcvr_ctl,
	input wire logic                        bus_wake_detect_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [15:0] hold_q;
	// Cycles spent in reset mode so far
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			hold_q <= '0;
		else if (mode == supply_mode_pkg::ST_RESET)
			hold_q <= hold_q + 16'h1;
		else
			hold_q <= '0;
	end
	hold_min_a: assert property (
		mode == supply_mode_pkg::ST_RESET && hold_q < RESET_HOLD_CYC - 1
		|=> mode == supply_mode_pkg::ST_RESET) else $error("reset left early");
	reset_oe_a: assert property (
		mode == supply_mode_pkg::ST_RESET && $stable(mode) |-> host_reset_line_oe)
		else $error("host reset not driven");
	await_only_a: assert property (
		mode == supply_mode_pkg::ST_AWAIT |-> supply_en == 3'h4 && !watchdog_run)
		else $error("await supplies wrong");
	wd_start_a: assert property (
		mode == supply_mode_pkg::ST_AWAIT && frame_end && frame.cmd == `CMD_WD_TIMING
		|=> mode == supply_mode_pkg::ST_NORMAL && watchdog_run) else $error("no normal entry");
	await_ignore_a: assert property (
		mode == supply_mode_pkg::ST_AWAIT && frame_end && !(frame.cmd inside {3'h1, 3'h5})
		|=> mode == supply_mode_pkg::ST_AWAIT) else $error("command not ignored");
	emerg_go_a: assert property (
		frame_end && frame.cmd == `CMD_EMERGENCY && mode inside {supply_mode_pkg::ST_AWAIT,
		supply_mode_pkg::ST_NORMAL, supply_mode_pkg::ST_STANDBY}
		|=> mode == supply_mode_pkg::ST_EMERG ##1 supply_en == 3'h0) else $error("no emergency");
	sleep_off_a: assert property (
		mode inside {supply_mode_pkg::ST_SLEEP, supply_mode_pkg::ST_EMERG}
		|-> supply_en[2:1] == 2'h0) else $error("regulators on");
	standby_sup_a: assert property (
		mode == supply_mode_pkg::ST_STANDBY |-> supply_en[2:1] == 2'h2 && watchdog_run)
		else $error("standby supplies wrong");
	low_pwr_a: assert property (
		mode != supply_mode_pkg::ST_NORMAL && $stable(mode) |-> xcvr_mode == `XCVR_LOW_POWER)
		else $error("transceiver not low power");
	full_ctl_a: assert property (
		xcvr_mode == `XCVR_FULL_DUPLEX |-> xcvr_ctl.tx_en && xcvr_ctl.rx_en
		&& xcvr_ctl.full_detect_en) else $error("full duplex controls wrong");
	lp_ctl_a: assert property (
		xcvr_mode == `XCVR_LOW_POWER |-> !xcvr_ctl.rx_en && !xcvr_ctl.canh_drv_en
		&& !xcvr_ctl.canl_drv_en && bus_wake_detect_en) else $error("low power controls wrong");
endmodule

// ===== test/host_model.sv
// Host side model: hands decoded SPI frames to the supervisor.
// Assumes each send is entered just after a rising clock edge.
`timescale 1ns/100ps
module host_model (
	input  wire logic                   clk,
	output supply_mode_pkg::spi_frame_t frame,
	output logic                        frame_end
);
	initial begin
		frame_end = 1'h0;
		frame = '0;
	end
	// Caller sends the watchdog timing word to enter normal; mode words by frame only
	task automatic send(logic [2:0] c, logic v, logic [1:0] x);
		@(posedge clk);
		#1;
		frame_end = 1'h1;
		frame = {c, v, x};
		@(posedge clk);
		#1;
		frame_end = 1'h0;
		frame = ~frame;
	endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the supply and CAN mode supervisor.
// Assumes the host model and the bound checker from this folder.
`timescale 1ns/100ps
`include "supply_mode_cfg.svh"
module tb;
	localparam int RH = 20;
	localparam int VF = 60;
	localparam int CW = 40;
	logic                        clk = 1'h0;
	logic                        resetn = 1'h0;
	logic                        wd_fault = 1'h0;
	logic                        logic_supply_low = 1'h0;
	logic                        xcvr_supply_overload = 1'h0;
	logic                        battery_loss_detection = 1'h0;
	logic                        host_pull = 1'h0;
	logic                        tx_in = 1'h1;
	logic                        bus_dominant = 1'h0;
	logic [4:0]                  wk = 5'h00;
	logic [7:0]                  failure = 8'h00;
	logic                        frame_end, rx_out, host_reset_line_oe, watchdog_run;
	logic                        bus_wake_detect_en;
	supply_mode_pkg::spi_frame_t frame;
	supply_mode_pkg::chip_mode_t mode;
	logic [1:0]                  xcvr_mode;
	supply_mode_pkg::supply_en_t supply_en;
	supply_mode_pkg::xcvr_ctl_t  xcvr_ctl;
	wire                         host_reset_in = host_reset_line_oe | host_pull;
	int                          failures = 0, samples_checked = 0, cyc = 0;

	supply_mode_supervisor #(.RESET_HOLD_CYC(RH), .V1_FAIL_CYC(VF), .CONFIG_WAIT_CYC(CW)) dut (
		.clk                   (clk),
		.resetn                (resetn),
		.frame_end             (frame_end),
		.frame                 (frame),
		.wd_fault              (wd_fault),
		.logic_supply_low      (logic_supply_low),
		.xcvr_supply_overload  (xcvr_supply_overload),
		.battery_loss_detection(battery_loss_detection),
		.host_reset_in         (host_reset_in),
		.wake_can              (wk[4]),
		.wake_cyclic           (wk[3]),
		.wake_permanent        (wk[2]),
		.wake_forced           (wk[1]),
		.wake_spi              (wk[0]),
		.tx_in                 (tx_in),
		.bus_dominant          (bus_dominant),
		.failure               (failure),
		.rx_out                (rx_out),
		.host_reset_line_o     (),
		.host_reset_line_oe    (host_reset_line_oe),
		.watchdog_run          (watchdog_run),
		.mode                  (mode),
		.xcvr_mode             (xcvr_mode),
		.supply_en             (supply_en),
		.xcvr_ctl              (xcvr_ctl),
		.bus_wake_detect_en    (bus_wake_detect_en)
	);
	host_model host (.clk(clk), .frame(frame), .frame_end(frame_end));

	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_mode(supply_mode_pkg::chip_mode_t m, int n);
		for (int i = 0; i < n && mode !== m; i++)
			tick(1);
		chk("mode", m, mode);
	endtask
	task automatic to_normal();
		host.send(`CMD_WD_TIMING, 1'h0, `XCVR_LOW_POWER);
		chk("config", supply_mode_pkg::ST_NORMAL, mode);
		chk("watchdog", 1'h1, watchdog_run);
	endtask

	task automatic t_boot();
		tick(RH / 2);
		chk("boot mode", supply_mode_pkg::ST_RESET, mode);
		chk("boot reset", 1'h1, host_reset_line_oe);
		wait_mode(supply_mode_pkg::ST_AWAIT, RH + 8);
		chk("await supply", 3'h4, supply_en);
		chk("await xcvr", `XCVR_LOW_POWER, xcvr_mode);
		$display("boot done");
	endtask
	task automatic t_config();
		host.send(`CMD_NORMAL, 1'h1, `XCVR_FULL_DUPLEX);
		chk("ignored", supply_mode_pkg::ST_AWAIT, mode);
		host.send(`CMD_SLEEP, 1'h0, `XCVR_LOW_POWER);
		chk("ignored", supply_mode_pkg::ST_AWAIT, mode);
		to_normal();
		host.send(`CMD_NORMAL, 1'h1, `XCVR_LOW_POWER);
		chk("v3 on", 3'h7, supply_en);
		host.send(`CMD_NORMAL, 1'h0, `XCVR_LOW_POWER);
		chk("v3 off", 3'h6, supply_en);
		$display("config done");
	endtask
	task automatic t_fail();
		supply_mode_pkg::xcvr_ctl_t b, e;
		host.send(`CMD_XCVR, 1'h1, `XCVR_FULL_DUPLEX);
		b = xcvr_ctl;
		for (int i = 0; i < 8; i++) begin
			e = b;
			if (i == 2 || i == 7)
				{e.high_term_ground_switch, e.canh_drv_en} = 2'h0;
			if (i == 3 || i == 5 || i == 6)
				{e.low_term_supply_switch, e.low_term_battery_switch, e.canl_drv_en} = 3'h0;
			failure = 8'h01 << i;
			tick(5);
			chk("failure ctl", e, xcvr_ctl);
			failure = 8'h00;
			tick(5);
		end
		$display("failures done");
	endtask
	task automatic t_xcvr();
		chk("full", 3'h7, {xcvr_ctl.tx_en, xcvr_ctl.rx_en, xcvr_ctl.full_detect_en});
		host.send(`CMD_XCVR, 1'h1, `XCVR_LISTEN_ONLY);
		chk("listen", 2'h1, {xcvr_ctl.tx_en, xcvr_ctl.rx_en});
		tx_in = 1'h0;
		tick(4);
		chk("rx tx low", 1'h0, rx_out);
		tx_in = 1'h1;
		tick(4);
		chk("rx idle", 1'h1, rx_out);
		bus_dominant = 1'h1;
		tick(4);
		chk("rx dominant", 1'h0, rx_out);
		bus_dominant = 1'h0;
		host.send(`CMD_XCVR, 1'h1, `XCVR_LOW_POWER);
		chk("low power", 2'h1, {xcvr_ctl.rx_en, xcvr_ctl.low_term_battery_switch});
		chk("wake detect", 1'h1, bus_wake_detect_en);
		host.send(`CMD_XCVR, 1'h1, `XCVR_FULL_DUPLEX);
		xcvr_supply_overload = 1'h1;
		tick(4);
		chk("overload", `XCVR_LOW_POWER, xcvr_mode);
		xcvr_supply_overload = 1'h0;
		tick(4);
		chk("overload sticky", `XCVR_LOW_POWER, xcvr_mode);
		$display("transceiver done");
	endtask
	task automatic t_standby();
		host.send(`CMD_STANDBY, 1'h1, `XCVR_LOW_POWER);
		chk("standby", supply_mode_pkg::ST_STANDBY, mode);
		chk("standby supply", 3'h5, supply_en);
		host.send(`CMD_XCVR, 1'h1, `XCVR_FULL_DUPLEX);
		chk("standby xcvr", `XCVR_LOW_POWER, xcvr_mode);
		host_pull = 1'h1;
		wait_mode(supply_mode_pkg::ST_RESET, 6);
		host_pull = 1'h0;
		wait_mode(supply_mode_pkg::ST_AWAIT, RH + 8);
		to_normal();
		logic_supply_low = 1'h1;
		wait_mode(supply_mode_pkg::ST_RESET, 6);
		tick(RH + 8);
		chk("held", supply_mode_pkg::ST_RESET, mode);
		wait_mode(supply_mode_pkg::ST_SLEEP, VF);
		logic_supply_low = 1'h0;
		wk = 5'h10;
		wait_mode(supply_mode_pkg::ST_AWAIT, RH + 12);
		wk = 5'h00;
		to_normal();
		wd_fault = 1'h1;
		wait_mode(supply_mode_pkg::ST_RESET, 6);
		wd_fault = 1'h0;
		wait_mode(supply_mode_pkg::ST_AWAIT, RH + 8);
		$display("standby done");
	endtask
	task automatic t_sleep();
		wait_mode(supply_mode_pkg::ST_SLEEP, CW + 8);
		for (int i = 0; i < 5; i++) begin
			wk = 5'h01 << i;
			wait_mode(supply_mode_pkg::ST_AWAIT, RH + 12);
			wk = 5'h00;
			to_normal();
			host.send(`CMD_SLEEP, 1'h0, `XCVR_LOW_POWER);
			chk("sleep cmd", supply_mode_pkg::ST_SLEEP, mode);
		end
		$display("sleep done");
	endtask
	task automatic t_emerg();
		wk = 5'h10;
		wait_mode(supply_mode_pkg::ST_AWAIT, RH + 12);
		wk = 5'h00;
		host.send(`CMD_EMERGENCY, 1'h0, `XCVR_LOW_POWER);
		chk("emergency", supply_mode_pkg::ST_EMERG, mode);
		chk("emerg supply", 3'h0, supply_en);
		wk = 5'h1F;
		tick(8);
		chk("emerg wake", supply_mode_pkg::ST_EMERG, mode);
		wk = 5'h00;
		battery_loss_detection = 1'h1;
		wait_mode(supply_mode_pkg::ST_RESET, 6);
		battery_loss_detection = 1'h0;
		wait_mode(supply_mode_pkg::ST_AWAIT, RH + 8);
		$display("emergency done");
	endtask

	initial begin
		repeat (16) @(posedge clk);
		#1 resetn = 1'h1;
		t_boot();
		t_config();
		t_fail();
		t_xcvr();
		t_standby();
		t_sleep();
		t_emerg();
		tally_and_finish();
	end
endmodule
bind supply_mode_supervisor supply_mode_props #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) props (
	.clk               (clk),
	.resetn            (resetn),
	.frame_end         (frame_end),
	.frame             (frame),
	.watchdog_run      (watchdog_run),
	.host_reset_line_oe(host_reset_line_oe),
	.mode              (mode),
	.xcvr_mode         (xcvr_mode),
	.supply_en         (supply_en),
	.xcvr_ctl          (xcvr_ctl),
	.bus_wake_detect_en(bus_wake_detect_en)
);
